// [rtl/sacw_clkdiv.sv]
`timescale 1ns/1ps
`default_nettype none

module sacw_clkdiv #(
   parameter int DIV_W = 5
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic run,
   input wire logic restart,
   input wire logic [DIV_W-1:0] divide,
   output logic tick
);

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
   } sacw_div_state_type;

   sacw_div_state_type s_r;
   sacw_div_state_type s_nxt;

   initial begin
      if (DIV_W < 1 || DIV_W > 8)
      begin
         $error("sacw_clkdiv: DIV_W out of range");
      end
   end

   // one tick per (divide + 1) system clocks
   assign tick = run && (s_r.cnt == divide);

   // counter restarts so a phase always gets full periods
   always_comb
   begin
      s_nxt = s_r;
      if (!run || restart || tick)
      begin
         s_nxt.cnt = '0;
      end
      else
      begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

endmodule : sacw_clkdiv

`default_nettype wire

// [rtl/sacw_pkg.sv]
package sacw_pkg;

   // register addresses on the special function register port
   localparam logic [7:0] ADDR_CFG = 8'hBC;
   localparam logic [7:0] ADDR_RES_LO = 8'hBE;
   localparam logic [7:0] ADDR_RES_HI = 8'hBF;
   localparam logic [7:0] ADDR_GT_LO = 8'hC4;
   localparam logic [7:0] ADDR_GT_HI = 8'hC5;
   localparam logic [7:0] ADDR_LT_LO = 8'hC6;
   localparam logic [7:0] ADDR_LT_HI = 8'hC7;
   localparam logic [7:0] ADDR_CTRL = 8'hE8;

   // configuration register fields
   localparam int CFG_DIV_LSB = 3;
   localparam int CFG_DIV_W = 5;
   localparam int CFG_GAIN_LSB = 0;
   localparam int CFG_GAIN_W = 3;

   // control register bit positions
   localparam int CTRL_EN = 7;
   localparam int CTRL_TM = 6;
   localparam int CTRL_DONE = 5;
   localparam int CTRL_BUSY = 4;
   localparam int CTRL_MODE_LSB = 2;
   localparam int CTRL_WIN = 1;
   localparam int CTRL_LJST = 0;

   // reset values
   localparam logic [7:0] CFG_RST = 8'hF8;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] RES_RST = 8'h00;
   localparam logic [7:0] GT_HI_RST = 8'hFF;
   localparam logic [7:0] GT_LO_RST = 8'hFF;
   localparam logic [7:0] LT_RST = 8'h00;

   // start-of-conversion sources
   localparam logic [1:0] START_SW = 2'h0;
   localparam logic [1:0] START_T3 = 2'h1;
   localparam logic [1:0] START_EXT = 2'h2;
   localparam logic [1:0] START_T2 = 2'h3;

   // timing in converter clock periods
   localparam int TRACK_CLOCKS = 3;
   localparam int CONV_CLOCKS = 16;

   // one-hot gain outputs: {x0.5, x16, x8, x4, x2, x1}
   localparam int GAIN_W = 6;

   typedef enum logic [1:0] {
      SACW_IDLE = 2'b00,
      SACW_TRACK = 2'b01,
      SACW_CONVERT = 2'b10
   } sacw_phase_type;

endpackage : sacw_pkg

// [rtl/sacw_top.sv]
// Function
// - converter clock is system clock over divider+1
// - decode three-bit gain field to gain select
// - enable bit off holds converter in shutdown
// - normal mode tracks except while converting
// - done flag set by hardware, cleared by software
// - busy reads conversion state; done on busy fall
// - busy write of one starts in mode 00
// - start mode selects software, timer3, pin, timer2
// - low-power mode tracks three clocks before converting
// - low-power pin mode tracks while pin low
// - window flag set on match, software clears
// - right justify, sign extend differential high nibble
// - left justify, low nibble reads zero
// - unsigned single-ended, two's complement differential
// - compare results against two sixteen-bit limits
// - greater-than high byte resets to all ones
// - conversion lasts at least sixteen converter clocks
`timescale 1ns/1ps
`default_nettype none

module sacw_top #(
   parameter int CONV_CLOCKS = sacw_pkg::CONV_CLOCKS,
   parameter int TRACK_CLOCKS = sacw_pkg::TRACK_CLOCKS
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic timer2_overflow,
   input wire logic timer3_overflow,
   input wire logic external_convert_start,
   input wire logic differential_mode,
   input wire logic [11:0] sar_result,
   output logic converter_active,
   output logic converter_tracking,
   output logic converter_clock,
   output logic sar_start,
   output logic conversion_busy,
   output logic [sacw_pkg::GAIN_W-1:0] amplifier_gain_select
);

   typedef struct packed {
      logic [4:0] conv_clock_divider;
      logic [2:0] gain_field;
      logic converter_enable;
      logic tracking_mode_select;
      logic conversion_done_flag;
      logic [1:0] start_mode_select;
      logic window_match_flag;
      logic left_justify_select;
      sacw_pkg::sacw_phase_type phase;
      logic [4:0] tick_cnt;
      logic [7:0] result_low_byte;
      logic [7:0] result_high_byte;
      logic [7:0] upper_limit_high_byte;
      logic [7:0] upper_limit_low_byte;
      logic [7:0] lower_limit_high_byte;
      logic [7:0] lower_limit_low_byte;
      logic ext_prev;
      logic start_pulse;
      logic [7:0] rdata;
      logic [sacw_pkg::GAIN_W-1:0] gain_onehot;
   } sacw_state_type;

   sacw_state_type s_r;
   sacw_state_type s_nxt;
   logic div_tick;
   logic div_restart;

   initial begin
      if (CONV_CLOCKS < 16 || CONV_CLOCKS > 31)
      begin
         $error("sacw_top: CONV_CLOCKS must be 16 to 31");
      end
      if (TRACK_CLOCKS < 1 || TRACK_CLOCKS > 31)
      begin
         $error("sacw_top: TRACK_CLOCKS must be 1 to 31");
      end
   end

   // gain field to one-hot gain select
   function automatic logic [sacw_pkg::GAIN_W-1:0] sacw_gain_decode(
      input logic [2:0] code
   );
      logic [sacw_pkg::GAIN_W-1:0] g;
      g = '0;
      case (code)
         3'h0: g = 6'h01; // gain 1
         3'h1: g = 6'h02; // gain 2
         3'h2: g = 6'h04; // gain 4
         3'h3: g = 6'h08; // gain 8
         3'h4, 3'h5: g = 6'h10; // gain 16
         default: g = 6'h20; // gain 0.5
      endcase
      return g;
   endfunction : sacw_gain_decode

   // place the 12-bit code into the 16-bit data word
   function automatic logic [15:0] sacw_justify(
      input logic [11:0] code,
      input logic diff,
      input logic ljst
   );
      logic [15:0] w;
      if (ljst)
      begin
         w = {code, 4'h0};
      end
      else
      begin
         w = {{4{diff & code[11]}}, code};
      end
      return w;
   endfunction : sacw_justify

   // window match; signed words are biased so one compare serves both
   function automatic logic sacw_window_hit(
      input logic [15:0] word,
      input logic [15:0] gt,
      input logic [15:0] lt,
      input logic sgn
   );
      logic [15:0] bias;
      logic [15:0] r;
      logic [15:0] g;
      logic [15:0] l;
      logic hit;
      bias = {sgn, 15'h0000};
      r = word ^ bias;
      g = gt ^ bias;
      l = lt ^ bias;
      if (l > g)
      begin
         hit = (r > g) && (r < l);
      end
      else
      begin
         hit = (r > g) || (r < l);
      end
      return hit;
   endfunction : sacw_window_hit

   // converter clock divider, restarted at each phase entry
   sacw_clkdiv #(
      .DIV_W(sacw_pkg::CFG_DIV_W)
   ) u_clkdiv (
      .clock(clock),
      .rst_n(rst_n),
      .run(s_r.converter_enable),
      .restart(div_restart),
      .divide(s_r.conv_clock_divider),
      .tick(div_tick)
   );

   assign div_restart = (s_nxt.phase != s_r.phase);

   // outputs toward the analog front end and the CPU
   assign sfr_rdata = s_r.rdata;
   assign sar_start = s_r.start_pulse;
   assign converter_clock = div_tick;
   assign converter_active = s_r.converter_enable;
   assign conversion_busy = (s_r.phase != sacw_pkg::SACW_IDLE);
   assign amplifier_gain_select = s_r.gain_onehot;

   // track-and-hold control per tracking mode
   always_comb
   begin
      converter_tracking = 1'b0;
      if (!s_r.converter_enable)
      begin
         converter_tracking = 1'b0;
      end
      else if (!s_r.tracking_mode_select)
      begin
         converter_tracking = (s_r.phase != sacw_pkg::SACW_CONVERT);
      end
      else if (s_r.start_mode_select == sacw_pkg::START_EXT)
      begin
         converter_tracking = (s_r.phase == sacw_pkg::SACW_IDLE) &&
            !external_convert_start;
      end
      else
      begin
         converter_tracking = (s_r.phase == sacw_pkg::SACW_TRACK);
      end
   end

   // register writes, triggers, sequencing and read-back
   always_comb
   begin
      logic wr_ctrl;
      logic sw_start;
      logic ext_rise;
      logic trig;
      logic finish;
      logic [15:0] word;
      logic [15:0] gt_word;
      logic [15:0] lt_word;
      wr_ctrl = 1'b0;
      sw_start = 1'b0;
      ext_rise = 1'b0;
      trig = 1'b0;
      finish = 1'b0;
      word = '0;
      gt_word = '0;
      lt_word = '0;
      s_nxt = s_r;
      s_nxt.start_pulse = 1'b0;
      s_nxt.ext_prev = external_convert_start;

      // software writes to the register file
      if (sfr_wr)
      begin
         case (sfr_addr)
            sacw_pkg::ADDR_CFG:
            begin
               s_nxt.conv_clock_divider = sfr_wdata[sacw_pkg::CFG_DIV_LSB +:
                  sacw_pkg::CFG_DIV_W];
               s_nxt.gain_field = sfr_wdata[sacw_pkg::CFG_GAIN_LSB +:
                  sacw_pkg::CFG_GAIN_W];
            end
            sacw_pkg::ADDR_CTRL:
            begin
               wr_ctrl = 1'b1;
               s_nxt.converter_enable = sfr_wdata[sacw_pkg::CTRL_EN];
               s_nxt.tracking_mode_select = sfr_wdata[sacw_pkg::CTRL_TM];
               s_nxt.conversion_done_flag = sfr_wdata[sacw_pkg::CTRL_DONE];
               s_nxt.start_mode_select =
                  sfr_wdata[sacw_pkg::CTRL_MODE_LSB +: 2];
               s_nxt.window_match_flag = sfr_wdata[sacw_pkg::CTRL_WIN];
               s_nxt.left_justify_select = sfr_wdata[sacw_pkg::CTRL_LJST];
            end
            sacw_pkg::ADDR_RES_LO: s_nxt.result_low_byte = sfr_wdata;
            sacw_pkg::ADDR_RES_HI: s_nxt.result_high_byte = sfr_wdata;
            sacw_pkg::ADDR_GT_LO: s_nxt.upper_limit_low_byte = sfr_wdata;
            sacw_pkg::ADDR_GT_HI: s_nxt.upper_limit_high_byte = sfr_wdata;
            sacw_pkg::ADDR_LT_LO: s_nxt.lower_limit_low_byte = sfr_wdata;
            sacw_pkg::ADDR_LT_HI: s_nxt.lower_limit_high_byte = sfr_wdata;
            default: s_nxt.rdata = s_r.rdata; // unmapped: ignored
         endcase
      end
      s_nxt.gain_onehot = sacw_gain_decode(s_nxt.gain_field);

      // busy write of one is the software trigger; zero does nothing
      sw_start = wr_ctrl && sfr_wdata[sacw_pkg::CTRL_BUSY] &&
         (sfr_wdata[sacw_pkg::CTRL_MODE_LSB +: 2] ==
         sacw_pkg::START_SW);
      ext_rise = external_convert_start && !s_r.ext_prev;

      // start source selection
      unique case (s_r.start_mode_select)
         sacw_pkg::START_SW: trig = sw_start;
         sacw_pkg::START_T3: trig = timer3_overflow;
         sacw_pkg::START_EXT: trig = ext_rise;
         sacw_pkg::START_T2: trig = timer2_overflow;
      endcase

      // conversion sequencer
      unique case (s_r.phase)
         sacw_pkg::SACW_IDLE:
         begin
            s_nxt.tick_cnt = '0;
            // triggers only taken when enabled and idle
            if (s_r.converter_enable && s_nxt.converter_enable && trig)
            begin
               if (s_r.tracking_mode_select &&
                  (s_r.start_mode_select != sacw_pkg::START_EXT))
               begin
                  s_nxt.phase = sacw_pkg::SACW_TRACK;
               end
               else
               begin
                  s_nxt.phase = sacw_pkg::SACW_CONVERT;
                  s_nxt.start_pulse = 1'b1;
               end
            end
         end
         sacw_pkg::SACW_TRACK:
         begin
            if (div_tick)
            begin
               if (s_r.tick_cnt == 5'(TRACK_CLOCKS - 1))
               begin
                  s_nxt.tick_cnt = '0;
                  s_nxt.phase = sacw_pkg::SACW_CONVERT;
                  s_nxt.start_pulse = 1'b1;
               end
               else
               begin
                  s_nxt.tick_cnt = s_r.tick_cnt + 5'h01;
               end
            end
         end
         sacw_pkg::SACW_CONVERT:
         begin
            if (div_tick)
            begin
               if (s_r.tick_cnt == 5'(CONV_CLOCKS - 1))
               begin
                  s_nxt.tick_cnt = '0;
                  s_nxt.phase = sacw_pkg::SACW_IDLE;
                  finish = 1'b1;
               end
               else
               begin
                  s_nxt.tick_cnt = s_r.tick_cnt + 5'h01;
               end
            end
         end
         default:
         begin
            s_nxt.phase = sacw_pkg::SACW_IDLE;
            s_nxt.tick_cnt = '0;
         end
      endcase

      // shutdown aborts any phase without completing it
      if (!s_nxt.converter_enable)
      begin
         s_nxt.phase = sacw_pkg::SACW_IDLE;
         s_nxt.tick_cnt = '0;
         s_nxt.start_pulse = 1'b0;
         finish = 1'b0;
      end

      // completion: load data, compare, raise flags (set beats clear)
      if (finish)
      begin
         word = sacw_justify(sar_result, differential_mode,
            s_r.left_justify_select);
         s_nxt.result_high_byte = word[15:8];
         s_nxt.result_low_byte = word[7:0];
         gt_word = {s_nxt.upper_limit_high_byte,
            s_nxt.upper_limit_low_byte};
         lt_word = {s_nxt.lower_limit_high_byte,
            s_nxt.lower_limit_low_byte};
         s_nxt.conversion_done_flag = 1'b1;
         if (sacw_window_hit(word, gt_word, lt_word, differential_mode))
         begin
            s_nxt.window_match_flag = 1'b1;
         end
      end

      // registered read-back, updated on each read strobe
      if (sfr_rd)
      begin
         case (sfr_addr)
            sacw_pkg::ADDR_CFG:
               s_nxt.rdata = {s_r.conv_clock_divider, s_r.gain_field};
            sacw_pkg::ADDR_CTRL:
               s_nxt.rdata = {s_r.converter_enable,
                  s_r.tracking_mode_select, s_r.conversion_done_flag,
                  conversion_busy, s_r.start_mode_select,
                  s_r.window_match_flag, s_r.left_justify_select};
            sacw_pkg::ADDR_RES_LO: s_nxt.rdata = s_r.result_low_byte;
            sacw_pkg::ADDR_RES_HI: s_nxt.rdata = s_r.result_high_byte;
            sacw_pkg::ADDR_GT_LO: s_nxt.rdata = s_r.upper_limit_low_byte;
            sacw_pkg::ADDR_GT_HI: s_nxt.rdata = s_r.upper_limit_high_byte;
            sacw_pkg::ADDR_LT_LO: s_nxt.rdata = s_r.lower_limit_low_byte;
            sacw_pkg::ADDR_LT_HI: s_nxt.rdata = s_r.lower_limit_high_byte;
            default: s_nxt.rdata = 8'h00;
         endcase
      end
   end

   // state register with documented reset values
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         s_r <= '0;
         s_r.conv_clock_divider <=
            sacw_pkg::CFG_RST[sacw_pkg::CFG_DIV_LSB +: sacw_pkg::CFG_DIV_W];
         s_r.gain_field <=
            sacw_pkg::CFG_RST[sacw_pkg::CFG_GAIN_LSB +: sacw_pkg::CFG_GAIN_W];
         s_r.converter_enable <= sacw_pkg::CTRL_RST[sacw_pkg::CTRL_EN];
         s_r.tracking_mode_select <= sacw_pkg::CTRL_RST[sacw_pkg::CTRL_TM];
         s_r.conversion_done_flag <= sacw_pkg::CTRL_RST[sacw_pkg::CTRL_DONE];
         s_r.start_mode_select <=
            sacw_pkg::CTRL_RST[sacw_pkg::CTRL_MODE_LSB +: 2];
         s_r.window_match_flag <= sacw_pkg::CTRL_RST[sacw_pkg::CTRL_WIN];
         s_r.left_justify_select <= sacw_pkg::CTRL_RST[sacw_pkg::CTRL_LJST];
         s_r.phase <= sacw_pkg::SACW_IDLE;
         s_r.result_low_byte <= sacw_pkg::RES_RST;
         s_r.result_high_byte <= sacw_pkg::RES_RST;
         s_r.upper_limit_high_byte <= sacw_pkg::GT_HI_RST;
         s_r.upper_limit_low_byte <= sacw_pkg::GT_LO_RST;
         s_r.lower_limit_high_byte <= sacw_pkg::LT_RST;
         s_r.lower_limit_low_byte <= sacw_pkg::LT_RST;
         s_r.gain_onehot <= 6'h01;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

endmodule : sacw_top

`default_nettype wire

// [sim/sacw_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module sacw_top_asserts #(
   parameter int CONV_CLOCKS = 16,
   parameter int TRACK_CLOCKS = 3
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic timer2_overflow,
   input wire logic timer3_overflow,
   input wire logic external_convert_start,
   input wire logic differential_mode,
   input wire logic [11:0] sar_result,
   input wire logic converter_active,
   input wire logic converter_tracking,
   input wire logic converter_clock,
   input wire logic sar_start,
   input wire logic conversion_busy,
   input wire logic [sacw_pkg::GAIN_W-1:0] amplifier_gain_select
);
   logic [9:0] run_r, run_nxt;
   logic seen_r, seen_nxt;
   // cycles since conversion phase began, start seen in this busy span
   always_comb
   begin
      run_nxt = (run_r == 10'h3ff) ? run_r : run_r + 10'h001;
      if (sar_start)
         run_nxt = 10'h001;
      seen_nxt = (seen_r | sar_start) & conversion_busy;
   end
   // helper registers
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         run_r <= 10'h000;
         seen_r <= 1'b0;
      end
      else
      begin
         run_r <= run_nxt;
         seen_r <= seen_nxt;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   gain_onehot_a: assert property ($onehot(amplifier_gain_select))
      else $error("gain select not one-hot");
   enable_follow_a: assert property (sfr_wr && sfr_addr == 8'he8
      |=> converter_active == $past(sfr_wdata[7]))
      else $error("active does not follow enable bit");
   off_quiet_a: assert property (!converter_active
      |-> !conversion_busy && !sar_start && !converter_tracking)
      else $error("converter works while shut down");
   start_hold_a: assert property (sar_start
      |-> conversion_busy && !converter_tracking)
      else $error("tracking during conversion start");
   start_pulse_a: assert property (sar_start |=> !sar_start)
      else $error("start pulse longer than one cycle");
   conv_length_a: assert property ($fell(conversion_busy)
      && converter_active |-> run_r >= CONV_CLOCKS)
      else $error("conversion shorter than minimum");
   no_retrigger_a: assert property (sar_start |-> !seen_r)
      else $error("second start within one busy span");
   busy_readback_a: assert property (sfr_rd && sfr_addr == 8'he8
      |=> sfr_rdata[4] == $past(conversion_busy))
      else $error("busy bit read differs from busy");
   busy_cause_a: assert property ($rose(conversion_busy)
      |-> sar_start || converter_tracking)
      else $error("busy rose without start or tracking");
endmodule : sacw_top_asserts
bind sacw_top sacw_top_asserts #(.CONV_CLOCKS(CONV_CLOCKS),
   .TRACK_CLOCKS(TRACK_CLOCKS)) sacw_top_asserts_i (.clock(clock),
   .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
   .timer2_overflow(timer2_overflow), .timer3_overflow(timer3_overflow),
   .external_convert_start(external_convert_start),
   .differential_mode(differential_mode), .sar_result(sar_result),
   .converter_active(converter_active),
   .converter_tracking(converter_tracking),
   .converter_clock(converter_clock), .sar_start(sar_start),
   .conversion_busy(conversion_busy),
   .amplifier_gain_select(amplifier_gain_select));
`default_nettype wire

// [sim/sacw_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sacw_top_tb_top;
   logic clock, rst_n, sfr_wr, sfr_rd, t2, t3, ext, diff;
   logic act, trk, cclk, start, busy;
   logic [7:0] addr, wdata, rdata;
   logic [11:0] res;
   logic [5:0] gain;
   int n_errors = 0;
   int total_checks = 0;
   sacw_top sacw_top_i (.clock(clock), .rst_n(rst_n), .sfr_addr(addr),
      .sfr_wr(sfr_wr), .sfr_wdata(wdata), .sfr_rd(sfr_rd),
      .sfr_rdata(rdata), .timer2_overflow(t2), .timer3_overflow(t3),
      .external_convert_start(ext), .differential_mode(diff),
      .sar_result(res), .converter_active(act),
      .converter_tracking(trk), .converter_clock(cclk),
      .sar_start(start), .conversion_busy(busy),
      .amplifier_gain_select(gain));
   // system clock
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic results;
      if (n_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, d);
      @(posedge clock);
      sfr_wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      sfr_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, exp, input string nm);
      @(posedge clock);
      sfr_rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      sfr_rd <= 1'b0;
      @(negedge clock);
      chk(nm, rdata, exp);
   endtask : rd
   task automatic wait_idle(output int n);
      n = 0;
      @(negedge clock);
      while (busy !== 1'b0 && n < 3000)
      begin
         n++;
         @(negedge clock);
      end
      // a conversion that never ends is a failure of its own
      if (n >= 3000)
      begin
         n_errors++;
         $display("[FAIL] busy_timeout expected 0 seen 1");
      end
   endtask : wait_idle
   task automatic pulse(input int s);
      @(posedge clock);
      t2 <= (s == 2);
      t3 <= (s == 3);
      ext <= (s == 1);
      @(posedge clock);
      t2 <= 1'b0;
      t3 <= 1'b0;
      ext <= 1'b0;
   endtask : pulse
   task automatic conv(input logic [7:0] c, input logic [11:0] r,
      input logic d, input int len, input logic [7:0] hi, lo);
      int n;
      @(posedge clock);
      res <= r;
      diff <= d;
      wr(8'he8, c);
      wait_idle(n);
      chk("length", 8'(n), 8'(len));
      rd(8'hbf, hi, "res_hi");
      rd(8'hbe, lo, "res_lo");
   endtask : conv
   task automatic t_reset;
      chk("gain", {2'b00, gain}, 8'h01);
      chk("active", {7'h0, act}, 8'h00);
      rd(8'hbc, 8'hf8, "cfg");
      rd(8'he8, 8'h00, "ctrl");
      rd(8'hc5, 8'hff, "gt_hi");
      rd(8'hc6, 8'h00, "lt_lo");
      rd(8'h00, 8'h00, "unmapped");
   endtask : t_reset
   task automatic t_gain;
      logic [5:0] e [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h10,
         6'h20, 6'h20};
      for (int i = 0; i < 8; i++)
      begin
         wr(8'hbc, 8'(i));
         repeat (2) @(negedge clock);
         chk("gain", {2'b00, gain}, {2'b00, e[i]});
      end
   endtask : t_gain
   task automatic t_soft;
      int k;
      wr(8'hbc, 8'h00);
      // enable first: a start is only taken while already enabled
      wr(8'he8, 8'h80);
      conv(8'h90, 12'habc, 1'b0, 16, 8'h0a, 8'hbc);
      rd(8'he8, 8'ha0, "ctrl");
      wr(8'hbc, 8'h10);
      // divider 2: one converter clock pulse every third cycle
      k = 0;
      repeat (9)
      begin
         @(negedge clock);
         k += cclk;
      end
      chk("cclk", 8'(k), 8'h03);
      conv(8'h91, 12'habc, 1'b0, 48, 8'hab, 8'hc0);
      conv(8'h90, 12'h800, 1'b1, 48, 8'hf8, 8'h00);
      conv(8'h90, 12'h800, 1'b0, 48, 8'h08, 8'h00);
      wr(8'he8, 8'h80);
      repeat (3) @(negedge clock);
      chk("busy", {7'h0, busy}, 8'h00);
      rd(8'he8, 8'h80, "ctrl");
      wr(8'he8, 8'h94);
      repeat (3) @(negedge clock);
      chk("busy", {7'h0, busy}, 8'h00);
   endtask : t_soft
   // trigger once, then again while busy, which must not extend busy
   task automatic trig(input logic [7:0] c, input int s, input logic e);
      wr(8'he8, c);
      pulse(s);
      repeat (3) @(negedge clock);
      chk("trigger", {7'h0, busy}, {7'h0, e});
      pulse(s);
      repeat (47) @(negedge clock);
      chk("retrigger", {7'h0, busy}, 8'h00);
   endtask : trig
   task automatic t_modes;
      trig(8'h84, 3, 1'b1);
      trig(8'h84, 2, 1'b0);
      trig(8'h8c, 2, 1'b1);
      trig(8'h8c, 3, 1'b0);
      trig(8'h88, 1, 1'b1);
      trig(8'h80, 3, 1'b0);
   endtask : t_modes
   task automatic t_lowpower;
      int n;
      wr(8'hbc, 8'h00);
      wait_idle(n);
      chk("idle_track", {7'h0, trk}, 8'h01);
      // tracking mode set before the start write that relies on it
      wr(8'he8, 8'hc0);
      wr(8'he8, 8'hd0);
      n = 0;
      @(negedge clock);
      chk("lp_track", {6'h0, busy, trk}, 8'h03);
      while (start !== 1'b1 && n < 100)
      begin
         n++;
         @(negedge clock);
      end
      chk("lp_delay", {7'h0, (n >= 3 && n <= 5)}, 8'h01);
      chk("lp_conv", {7'h0, trk}, 8'h00);
      wait_idle(n);
      wr(8'he8, 8'hc8);
      repeat (2) @(negedge clock);
      chk("pin_track", {6'h0, busy, trk}, 8'h01);
      @(posedge clock);
      ext <= 1'b1;
      repeat (3) @(negedge clock);
      chk("pin_conv", {6'h0, busy, trk}, 8'h02);
      wait_idle(n);
      @(posedge clock);
      ext <= 1'b0;
   endtask : t_lowpower
   task automatic lim(input logic [15:0] g, l);
      wr(8'hc5, g[15:8]);
      wr(8'hc4, g[7:0]);
      wr(8'hc7, l[15:8]);
      wr(8'hc6, l[7:0]);
   endtask : lim
   task automatic wc(input logic [11:0] r, input logic [7:0] e);
      int n;
      @(posedge clock);
      res <= r;
      pulse(3);
      wait_idle(n);
      rd(8'he8, e, "window");
   endtask : wc
   task automatic t_window;
      wr(8'he8, 8'h84);
      lim(16'h0200, 16'h0100);
      wc(12'h300, 8'ha6);
      wc(12'h150, 8'ha6);
      wr(8'he8, 8'h84);
      wc(12'h150, 8'ha4);
      lim(16'h0100, 16'h0200);
      wc(12'h150, 8'ha6);
      wr(8'he8, 8'h84);
      wc(12'h050, 8'ha4);
   endtask : t_window
   task automatic t_shutdown;
      // back to software start mode before the busy write
      wr(8'he8, 8'h80);
      wr(8'he8, 8'h90);
      repeat (3) @(negedge clock);
      chk("on", {6'h0, act, busy}, 8'h03);
      wr(8'he8, 8'h00);
      @(negedge clock);
      chk("off", {5'h0, act, busy, trk}, 8'h00);
      wr(8'he8, 8'h10);
      repeat (3) @(negedge clock);
      chk("off_start", {7'h0, busy}, 8'h00);
      rd(8'he8, 8'h00, "ctrl");
   endtask : t_shutdown
   // main sequence
   initial
   begin
      {rst_n, sfr_wr, sfr_rd, t2, t3, ext, diff} = 7'h00;
      addr = 8'h00;
      wdata = 8'h00;
      res = 12'h000;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      t_reset;
      t_gain;
      t_soft;
      t_modes;
      t_lowpower;
      t_window;
      t_shutdown;
      results;
   end
   // watchdog
   initial
   begin
      #(20000 * 25);
      n_errors++;
      results;
   end
endmodule : sacw_top_tb_top
`default_nettype wire
